//--- dual_port_semaphore_flags_tb.sv
// Self-checking bench for the semaphore port controller.
// Assumes the device model above; the bench plays the far port itself.
`timescale 1ns/1ps
`default_nettype none
module dual_port_semaphore_flags_tb;
   import sem_pkg::*;
   // ************************************************************
   // Signals
   // ************************************************************
   logic clk_sys_i = 1'b0;
   logic nrst_i = 1'b0;
   logic cmd_valid_i = 1'b0;
   cmd_type cmd_i = '{OP_READ, 3'h0};
   logic cmd_ready_o, done_o, granted_o, flag_o;
   logic array_select_n_o, semaphore_select_n_o, out_en_n_o, write_n_o;
   logic [12:0] addr_o;
   logic [17:0] data_o, data_oe_o, data_i;
   logic b_sem_n = 1'b1; // Far port select
   logic b_oe_n = 1'b1; // Far port enable
   logic b_wr_n = 1'b1; // Far port strobe
   logic [2:0] b_idx = 3'h0; // Far port flag index
   logic b_d0 = 1'b1; // Far port write value
   logic b_q; // Far port read value
   logic q; // Last far read
   int fails = 0;
   int total_checks = 0;
   int cycles = 0;

   always #20 clk_sys_i = ~clk_sys_i; // 25 MHz

   // Short poll count keeps the failed-acquire path brief
   sem_host #(.MAX_POLL(2)) sem_host_inst (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
      .granted_o(granted_o), .flag_o(flag_o),
      .array_select_n_o(array_select_n_o),
      .semaphore_select_n_o(semaphore_select_n_o),
      .out_en_n_o(out_en_n_o), .write_n_o(write_n_o), .addr_o(addr_o),
      .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i));

   sem_device_model sem_device_model_inst (
      .a_array_n_i(array_select_n_o), .a_sem_n_i(semaphore_select_n_o),
      .a_oe_n_i(out_en_n_o), .a_wr_n_i(write_n_o), .a_addr_i(addr_o),
      .a_d0_i(data_o[0]), .a_data_o(data_i), .b_sem_n_i(b_sem_n),
      .b_oe_n_i(b_oe_n), .b_wr_n_i(b_wr_n), .b_idx_i(b_idx),
      .b_d0_i(b_d0), .b_q_o(b_q));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic check(input string what, input logic exp, input logic got);
      total_checks++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
         fails++;
      end
   endtask

   // One command: hold valid until taken, then wait for done
   task automatic run_cmd(input op_type op, input logic [2:0] idx);
      int n;
      logic [2:0] exp_idx;
      n = 0;
      // An init sweep leaves the address on the last flag
      exp_idx = (op == OP_INIT) ? INDEX_LAST : idx;
      @(posedge clk_sys_i);
      cmd_valid_i <= 1'b1;
      cmd_i <= '{op, idx};
      do
      begin
         @(posedge clk_sys_i);
         n++;
      end
      while (cmd_ready_o !== 1'b1 && n < 100);
      cmd_valid_i <= 1'b0;
      n = 0;
      do
      begin
         @(posedge clk_sys_i);
         #1;
         n++;
      end
      while (done_o !== 1'b1 && n < 400);
      check("done", 1'b1, done_o);
      check("array select", 1'b1, array_select_n_o);
      check("standby", 1'b1, semaphore_select_n_o & write_n_o &
         out_en_n_o & ~data_oe_o[0]);
      check("flag index", 1'b1, addr_o[2:0] === exp_idx);
   endtask

   // Far port access of three cycles, deselected afterwards
   task automatic b_acc(input logic wr, input logic v, input logic [2:0] i);
      @(posedge clk_sys_i);
      b_sem_n <= 1'b0;
      b_idx <= i;
      b_d0 <= v;
      if (wr)
         b_wr_n <= 1'b0;
      else
         b_oe_n <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
      q = b_q;
      b_sem_n <= 1'b1;
      b_wr_n <= 1'b1;
      b_oe_n <= 1'b1;
      @(posedge clk_sys_i);
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   // Both sides free every flag, then every flag reads free
   task automatic s_init();
      run_cmd(OP_INIT, 3'h0);
      for (int i = 0; i < FLAG_COUNT; i++)
         b_acc(1'b1, FLAG_RELEASE, i[2:0]);
      for (int i = 0; i < FLAG_COUNT; i++)
      begin
         run_cmd(OP_READ, i[2:0]);
         check("free flag", 1'b1, flag_o);
      end
   endtask

   // Take, far side queues, hand-over, failed take with withdraw
   task automatic s_handover();
      run_cmd(OP_ACQUIRE, 3'h3);
      check("granted", 1'b1, granted_o);
      check("held flag", 1'b0, flag_o);
      b_acc(1'b0, 1'b0, 3'h3);
      check("far sees taken", 1'b1, q);
      b_acc(1'b1, FLAG_REQUEST, 3'h3);
      b_acc(1'b0, 1'b0, 3'h3);
      check("far pending", 1'b1, q);
      run_cmd(OP_RELEASE, 3'h3);
      b_acc(1'b0, 1'b0, 3'h3);
      check("far took over", 1'b0, q);
      run_cmd(OP_READ, 3'h3);
      check("lost flag", 1'b1, flag_o);
      run_cmd(OP_ACQUIRE, 3'h3);
      check("refused", 1'b0, granted_o);
      check("refused flag", 1'b1, flag_o);
      // Our withdrawn request must not disturb the far holder
      b_acc(1'b0, 1'b0, 3'h3);
      check("far still holds", 1'b0, q);
      b_acc(1'b1, FLAG_RELEASE, 3'h3);
      b_acc(1'b0, 1'b0, 3'h3);
      check("withdrawn free", 1'b1, q);
   endtask

   // A one from the side without the token changes nothing
   task automatic s_nonholder();
      run_cmd(OP_ACQUIRE, 3'h6);
      check("granted 6", 1'b1, granted_o);
      b_acc(1'b1, FLAG_RELEASE, 3'h6);
      run_cmd(OP_READ, 3'h6);
      check("still held", 1'b0, flag_o);
      run_cmd(OP_RELEASE, 3'h6);
      b_acc(1'b0, 1'b0, 3'h6);
      check("freed 6", 1'b1, q);
   endtask

   // ************************************************************
   // Run control
   // ************************************************************
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Hang guard, well above the few hundred cycles the run needs
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         fails++;
         final_report();
      end
   end

   initial
   begin
      repeat (10) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      s_init();
      s_handover();
      s_nonholder();
      final_report();
   end
endmodule
`default_nettype wire

//--- sem_device_model.sv
// Behavioural model of the two-port semaphore part: eight flags, two ports.
// Assumes port A faces the controller and port B is driven by the bench.
`timescale 1ns/1ps
`default_nettype none
module sem_device_model
   import sem_pkg::*;
(
   input wire logic a_array_n_i,
   input wire logic a_sem_n_i,
   input wire logic a_oe_n_i,
   input wire logic a_wr_n_i,
   input wire logic [12:0] a_addr_i,
   input wire logic a_d0_i,
   output logic [17:0] a_data_o,
   input wire logic b_sem_n_i,
   input wire logic b_oe_n_i,
   input wire logic b_wr_n_i,
   input wire logic [2:0] b_idx_i,
   input wire logic b_d0_i,
   output logic b_q_o
);
   // ************************************************************
   // Flag state
   // ************************************************************
   // Power-up garbage: every request latch starts pending, so a
   // missing initialisation shows up as a stray hand-over
   logic [7:0] req_a = 8'h00; // Request latches, zero = request
   logic [7:0] req_b = 8'h00; // Far side latches
   logic [1:0] own [8] = '{default: 2'h0}; // 0 free, 1 port A, 2 port B
   logic out_a = 1'b1; // Port A output latch
   logic out_b = 1'b1; // Port B output latch
   logic standby_a; // Port A idle
   assign standby_a = a_sem_n_i & a_array_n_i;

   // Latch update for one write; no wait state, nothing gated
   task automatic put(input logic sb, input logic [2:0] i, input logic v);
      logic [1:0] me;
      me = sb ? 2'h2 : 2'h1;
      if (sb)
         req_b[i] = v;
      else
         req_a[i] = v;
      // Zero takes a free flag, first writer wins
      if (v == FLAG_REQUEST)
      begin
         if (own[i] == 2'h0)
            own[i] = me;
      end
      // Holder frees or hands over
      else if (own[i] == me)
      begin
         if ((sb ? req_a[i] : req_b[i]) == FLAG_REQUEST)
            own[i] = 2'h3 - me;
         else
            own[i] = 2'h0;
      end
      // Non-holder one only cleared its own latch above
   endtask

   // ************************************************************
   // Port accesses
   // ************************************************************
   // Writes sample only data bit 0, a little after the strobe falls
   always @(negedge (a_sem_n_i | a_wr_n_i))
   begin
      #1;
      if (a_array_n_i && !standby_a)
         put(1'b0, a_addr_i[2:0], a_d0_i);
   end
   always @(negedge (b_sem_n_i | b_wr_n_i))
   begin
      #1;
      put(1'b1, b_idx_i, b_d0_i);
   end
   // Read value latched when select and enable both go active
   always @(negedge (a_sem_n_i | a_oe_n_i))
   begin
      #1;
      out_a = (own[a_addr_i[2:0]] != 2'h1);
   end
   always @(negedge (b_sem_n_i | b_oe_n_i))
   begin
      #1;
      out_b = (own[b_idx_i] != 2'h2);
   end
   // Replicated on all bits; released pins show the inverse
   assign a_data_o = (!a_sem_n_i && !a_oe_n_i) ? {18{out_a}} : {18{~out_a}};
   assign b_q_o = (!b_sem_n_i && !b_oe_n_i) ? out_b : ~out_b;
endmodule
`default_nettype wire

//--- sem_host.sv
// Controller for one port of a dual-port semaphore part.
// Assumes a user issues one command at a time on a valid/ready port and the
// other port is driven by an independent party.
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Select low, then SRAM-style address and strobes
// - Hold array select high during semaphore access
// - Deselect between successive polling reads
// - Write zero first, then read back
// - After failure re-read or write one
// - Software writes one into all flags initially
module sem_host
   import sem_pkg::*;
#(
   parameter int unsigned ADDR_W = 13,
   parameter int unsigned DATA_W = 18,
   parameter int unsigned MAX_POLL = MAX_POLL_DEF
)
(
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic cmd_valid_i,
   input wire cmd_type cmd_i,
   output logic cmd_ready_o,
   output logic done_o,
   output logic granted_o,
   output logic flag_o,
   output logic array_select_n_o,
   output logic semaphore_select_n_o,
   output logic out_en_n_o,
   output logic write_n_o,
   output logic [ADDR_W-1:0] addr_o,
   output logic [DATA_W-1:0] data_o,
   output logic [DATA_W-1:0] data_oe_o,
   input wire logic [DATA_W-1:0] data_i
);
   // ****************************************************************
   // Reset release
   // ****************************************************************
   logic rst_a_q; // First reset flop
   logic rst_n; // Synchronised reset used everywhere
   always_ff @(posedge clk_sys_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_a_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_a_q <= 1'b1;
         rst_n <= rst_a_q;
      end
   end

   // ****************************************************************
   // Data pin synchroniser
   // ****************************************************************
   logic [DATA_W-1:0] data_st; // Filtered data pins
   sem_pin_sync #(.WIDTH(DATA_W)) u_sync
   (
      .clk_sys_i(clk_sys_i),
      .rst_n_i(rst_n),
      .pin_i(data_i),
      .stable_o(data_st)
   );

   // ****************************************************************
   // Sequencer state
   // ****************************************************************
   state_type state_q, state_d; // Access sequencer
   logic [3:0] cnt_q, cnt_d; // Cycles spent in a phase
   op_type op_q, op_d; // Command being served
   logic [INDEX_W-1:0] idx_q, idx_d; // Flag under access
   logic [3:0] polls_q, polls_d; // Re-reads done after a failed request
   logic last_rd_q, last_rd_d; // Last access was a read
   logic wr_val_q, wr_val_d; // Value written on the lowest data bit
   logic flag_q, flag_d; // Last flag value read
   logic granted_q, granted_d; // Acquire outcome
   logic done_q, done_d; // One-cycle completion pulse
   logic ready_q, ready_d; // Command port ready
   pins_type pins_q, pins_d; // Registered pin drive

   // Next-state computation
   always_comb
   begin
      state_d = state_q;
      cnt_d = cnt_q + 4'h1;
      op_d = op_q;
      idx_d = idx_q;
      polls_d = polls_q;
      last_rd_d = last_rd_q;
      wr_val_d = wr_val_q;
      flag_d = flag_q;
      granted_d = granted_q;
      done_d = 1'b0;
      unique case (state_q)
         ST_IDLE:
         begin
            cnt_d = 4'h0;
            if (cmd_valid_i && ready_q)
            begin
               op_d = cmd_i.op;
               idx_d = cmd_i.flag_index;
               polls_d = 4'h0;
               granted_d = 1'b0;
               if (cmd_i.op == OP_READ)
               begin
                  state_d = ST_READ;
               end
               else if (cmd_i.op == OP_ACQUIRE)
               begin
                  // Write first, never read first
                  wr_val_d = FLAG_REQUEST;
                  state_d = ST_WRITE;
               end
               else
               begin
                  wr_val_d = FLAG_RELEASE;
                  if (cmd_i.op == OP_INIT)
                  begin
                     idx_d = '0; // Start init sweep at flag zero
                  end
                  state_d = ST_WRITE;
               end
            end
         end
         ST_WRITE:
         begin
            if (cnt_q == 4'(WR_CYC - 1))
            begin
               last_rd_d = 1'b0;
               cnt_d = 4'h0;
               state_d = ST_GAP;
            end
         end
         ST_READ:
         begin
            // Sample after access time plus pin latency
            if (cnt_q == 4'(RD_CYC - 1))
            begin
               flag_d = data_st[0];
               last_rd_d = 1'b1;
               cnt_d = 4'h0;
               state_d = ST_GAP;
            end
         end
         ST_GAP:
         begin
            // Deselected so the next read relatches the flag
            if (cnt_q == 4'(GAP_CYC - 1))
            begin
               cnt_d = 4'h0;
               state_d = ST_DONE;
               if (op_q == OP_INIT && idx_q != INDEX_LAST)
               begin
                  idx_d = idx_q + 3'h1; // Next flag of sweep
                  state_d = ST_WRITE;
               end
               else if (op_q == OP_ACQUIRE && !last_rd_q &&
                        wr_val_q == FLAG_REQUEST)
               begin
                  state_d = ST_READ; // Read back the request
               end
               else if (op_q == OP_ACQUIRE && last_rd_q)
               begin
                  if (flag_q == FLAG_REQUEST)
                  begin
                     granted_d = 1'b1; // Zero read back: we hold it
                  end
                  else if (polls_q < 4'(MAX_POLL))
                  begin
                     polls_d = polls_q + 4'h1; // Keep polling
                     state_d = ST_READ;
                  end
                  else
                  begin
                     // Withdraw the pending request
                     wr_val_d = FLAG_RELEASE;
                     state_d = ST_WRITE;
                  end
               end
            end
         end
         ST_DONE:
         begin
            done_d = 1'b1;
            cnt_d = 4'h0;
            state_d = ST_IDLE;
         end
      endcase
      ready_d = (state_d == ST_IDLE); // Never waits on a held request
      // Pin drive follows the next state so pins come from flops
      pins_d = PINS_IDLE; // Both selects high: standby
      if (state_d == ST_WRITE)
      begin
         pins_d.semaphore_select_n = 1'b0;
         pins_d.write_n = 1'b0;
         pins_d.data0 = wr_val_d;
         pins_d.data0_oe = 1'b1;
      end
      else if (state_d == ST_READ)
      begin
         pins_d.semaphore_select_n = 1'b0;
         pins_d.out_en_n = 1'b0;
      end
   end

   // Register the sequencer
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
         op_q <= OP_READ;
         idx_q <= '0;
         polls_q <= 4'h0;
         last_rd_q <= 1'b0;
         wr_val_q <= 1'b1;
         flag_q <= 1'b1;
         granted_q <= 1'b0;
         done_q <= 1'b0;
         ready_q <= 1'b0;
         pins_q <= PINS_IDLE;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         op_q <= op_d;
         idx_q <= idx_d;
         polls_q <= polls_d;
         last_rd_q <= last_rd_d;
         wr_val_q <= wr_val_d;
         flag_q <= flag_d;
         granted_q <= granted_d;
         done_q <= done_d;
         ready_q <= ready_d;
         pins_q <= pins_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // Upper address held at zero; the part ignores it anyway
   assign addr_o = {{(ADDR_W-INDEX_W){1'b0}}, idx_q};
   assign data_o = {{(DATA_W-1){1'b1}}, pins_q.data0};
   assign data_oe_o = {{(DATA_W-1){1'b0}}, pins_q.data0_oe};
   assign array_select_n_o = pins_q.array_select_n;
   assign semaphore_select_n_o = pins_q.semaphore_select_n;
   assign out_en_n_o = pins_q.out_en_n;
   assign write_n_o = pins_q.write_n;
   assign cmd_ready_o = ready_q;
   assign done_o = done_q;
   assign granted_o = granted_q;
   assign flag_o = flag_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   logic [3:0] wr_len_q; // Helper: length of current write strobe
   always_ff @(posedge clk_sys_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wr_len_q <= 4'h0;
      end
      else
      begin
         wr_len_q <= write_n_o ? 4'h0 : wr_len_q + 4'h1;
      end
   end

   sequence rd_phase_s;
      !semaphore_select_n_o && !out_en_n_o;
   endsequence
   sequence deselect_s;
      semaphore_select_n_o;
   endsequence

   array_held_high_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) array_select_n_o) else $error("Array select driven low");
   write_in_sem_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) !write_n_o |-> !semaphore_select_n_o && out_en_n_o && data_oe_o[0]) else $error("Write outside semaphore select");
   upper_addr_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) addr_o[ADDR_W-1:INDEX_W] == '0) else $error("Upper address not zero");
   one_data_bit_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) data_oe_o[DATA_W-1:1] == '0) else $error("Upper data bits driven");
   write_len_exact_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) $rose(write_n_o) |-> wr_len_q == 4'(WR_CYC)) else $error("Write strobe length wrong");
   poll_deselect_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) rd_phase_s ##1 (semaphore_select_n_o || out_en_n_o) |-> deselect_s) else $error("No deselect after read");
   acquire_write_first_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) (state_q == ST_IDLE && cmd_valid_i && ready_q && cmd_i.op == OP_ACQUIRE) |=> !write_n_o && data_o[0] == 1'b0) else $error("Acquire did not write zero first");
   fail_withdraw_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) (done_o && op_q == OP_ACQUIRE && !granted_o) |-> wr_val_q == FLAG_RELEASE) else $error("Failed acquire left request pending");
   init_writes_one_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) (op_q == OP_INIT && !write_n_o) |-> data_o[0]) else $error("Init wrote zero");
   grant_on_zero_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) $rose(granted_o) |-> flag_o == 1'b0 ##1 done_o) else $error("Grant without zero read");
   standby_idle_a: assert property (@(posedge clk_sys_i) disable iff (!rst_n) (state_q == ST_IDLE) |-> semaphore_select_n_o && array_select_n_o) else $error("Idle port not in standby");
endmodule
`default_nettype wire

//--- sem_pin_sync.sv
// Three-flop synchroniser for a group of pin inputs.
// Assumes the pins are asynchronous to clk_sys_i; a bit changes only once
// the second and third flops agree.
`timescale 1ns/1ps
`default_nettype none
module sem_pin_sync
#(
   parameter int unsigned WIDTH = 18
)
(
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] stable_o
);
   // ****************************************************************
   // Per-bit flop chain
   // ****************************************************************
   genvar b;
   generate
      for (b = 0; b < WIDTH; b = b + 1)
      begin : g_bit
         logic s1_q; // First flop, read only by the second
         logic s2_q;
         logic s3_q;
         logic st_q; // Filtered value
         logic st_d;
         // Accept a change only when two late stages agree
         always_comb
         begin
            st_d = st_q;
            if (s2_q == s3_q)
            begin
               st_d = s3_q;
            end
         end
         // Register the chain
         always_ff @(posedge clk_sys_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               s1_q <= 1'b1;
               s2_q <= 1'b1;
               s3_q <= 1'b1;
               st_q <= 1'b1;
            end
            else
            begin
               s1_q <= pin_i[b];
               s2_q <= s1_q;
               s3_q <= s2_q;
               st_q <= st_d;
            end
         end
         assign stable_o[b] = st_q;
      end
   endgenerate
endmodule
`default_nettype wire

//--- sem_pkg.sv
// Shared constants and carrier types for the semaphore port controller.
// Assumes one 25 MHz system clock and one port of a dual-port semaphore part.
package sem_pkg;
   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int unsigned CLK_PERIOD_NS = 40; // 25 MHz system clock
   localparam int unsigned T_WR_PULSE_NS = 80; // Least write strobe width
   localparam int unsigned T_RD_ACC_NS = 120; // Least read access time
   localparam int unsigned T_GAP_NS = 40; // Least deselect between accesses
   localparam int unsigned SYNC_STAGES = 3; // Pin input flops
   // Least times round up to whole cycles
   localparam int unsigned WR_CYC =
      (T_WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RD_CYC =
      (T_RD_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES;
   localparam int unsigned GAP_CYC =
      (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ****************************************************************
   // Flag space and reset values
   // ****************************************************************
   localparam int unsigned FLAG_COUNT = 8; // Number of semaphore flags
   localparam int unsigned INDEX_W = 3; // Flag index width
   localparam logic [INDEX_W-1:0] INDEX_LAST = 3'h7; // Highest flag index
   localparam logic FLAG_REQUEST = 1'b0; // Zero requests the token
   localparam logic FLAG_RELEASE = 1'b1; // One releases the token
   localparam int unsigned MAX_POLL_DEF = 4; // Re-reads before withdrawing

   // ****************************************************************
   // Commands, states, carriers
   // ****************************************************************
   typedef enum logic [1:0]
   {
      OP_ACQUIRE = 2'h0, // Write zero, read back, poll or withdraw
      OP_RELEASE = 2'h1, // Write one
      OP_READ = 2'h2, // Plain read of one flag
      OP_INIT = 2'h3 // Write one into all eight flags
   } op_type;

   typedef enum logic [4:0]
   {
      ST_IDLE = 5'h01,
      ST_WRITE = 5'h02,
      ST_READ = 5'h04,
      ST_GAP = 5'h08,
      ST_DONE = 5'h10
   } state_type;

   typedef struct packed
   {
      op_type op; // Requested operation
      logic [INDEX_W-1:0] flag_index; // Flag addressed
   } cmd_type;

   typedef struct packed
   {
      logic array_select_n; // Memory array select, held high
      logic semaphore_select_n; // Semaphore space select
      logic out_en_n; // Output drive enable
      logic write_n; // Write strobe
      logic data0; // Written value on the lowest data bit
      logic data0_oe; // High while we drive the lowest data bit
   } pins_type;

   localparam pins_type PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
endpackage
